// ### include/rfc_baud_if.sv
// carrier between the core and its bit-rate divider
`timescale 1ns/1ps
interface rfc_baud_if;
  import rfc_pkg::*;
  rfc_baud_t baud_sel;
  logic tick;
  modport gen (input baud_sel, output tick);
  modport user (output baud_sel, input tick);
endinterface

// ### include/rfc_pkg.sv
// types of the remote interface and flow control block
package rfc_pkg;

  // ==========================================================
  // serial configuration
  typedef enum logic [2:0] {
    RFC_B2400 = 3'h0,
    RFC_B4800 = 3'h1,
    RFC_B9600 = 3'h2,
    RFC_B19200 = 3'h3,
    RFC_B38400 = 3'h4,
    RFC_B57600 = 3'h5
  } rfc_baud_t;

  typedef enum logic [1:0] {
    RFC_NONE_8 = 2'h0,
    RFC_EVEN_7 = 2'h1,
    RFC_ODD_7 = 2'h2
  } rfc_frame_t;

  typedef enum logic [1:0] {
    RFC_FLOW_NONE = 2'h0,
    RFC_FLOW_XON = 2'h1,
    RFC_FLOW_DTR = 2'h2,
    RFC_FLOW_RTS = 2'h3
  } rfc_flow_t;

  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    RFC_S_IDLE = 4'h1,
    RFC_S_START = 4'h2,
    RFC_S_DATA = 4'h4,
    RFC_S_STOP = 4'h8
  } rfc_ser_st_t;

  typedef enum logic [2:0] {
    RFC_BOOT_LOAD = 3'h1,
    RFC_BOOT_APPLY = 3'h2,
    RFC_BOOT_DONE = 3'h4
  } rfc_boot_st_t;

endpackage

// ### include/rfc_regs.svh
// constants of the remote interface and flow control block
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH

// ==========================================================
// clock and timing
`define RFC_CLK_HZ 100000000
`define RFC_OVERSAMPLE 16
`define RFC_HALF_BIT 4'h7
`define RFC_LAST_TICK 4'hf

// ==========================================================
// bit rates in baud
`define RFC_RATE_2400 2400
`define RFC_RATE_4800 4800
`define RFC_RATE_9600 9600
`define RFC_RATE_19200 19200
`define RFC_RATE_38400 38400
`define RFC_RATE_57600 57600

// ==========================================================
// flow control characters
`define RFC_XOFF_CHAR 8'h13
`define RFC_XON_CHAR 8'h11

// ==========================================================
// receive buffer
`define RFC_RX_DEPTH 128
`define RFC_RX_ALMOST_FULL 100

// ==========================================================
// instrument bus address
`define RFC_GPIB_ADDR_MAX 5'h1e
`define RFC_GPIB_ADDR_FACTORY 5'h09

// ==========================================================
// self-test code meaning success
`define RFC_SELFTEST_PASS 8'h00

`endif

// ### verif/rfc_host.sv
// host computer model sending characters to the serial port
`timescale 1ns/1ps
module rfc_host #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic sys_clk,
  // line toward the device, idles at mark
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] ch);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      rxd = fr[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
  endtask
endmodule

// ### verif/rfc_top_asserts.sv
// concurrent checks on the remote interface block ports
`timescale 1ns/1ps
module rfc_top_asserts (
  // block inputs
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scpi_mode,
  input wire logic addr_wr,
  input wire logic [4:0] addr_wdata,
  input wire logic nv_srq_en,
  input wire logic nv_boot_default,
  input wire logic [3:0] nv_slot,
  input wire logic nv_slot_valid,
  input wire logic srq_ack,
  input wire logic st_done,
  input wire logic [7:0] st_code,
  // block outputs
  input wire logic nv_addr_wr,
  input wire logic [4:0] nv_addr_wdata,
  input wire logic gpib_active,
  input wire logic serial_active,
  input wire logic [4:0] gpib_addr,
  input wire logic srq_pwrup,
  input wire logic boot_done,
  input wire logic boot_to_default_state,
  input wire logic recall_req,
  input wire logic [3:0] recall_slot,
  input wire logic stored_setup_invalid_msg,
  input wire logic st_pass,
  input wire logic st_fail,
  input wire logic [7:0] st_reason
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // address write: store, then show
  sequence s_store;
    nv_addr_wr && nv_addr_wdata == $past(addr_wdata);
  endsequence
  sequence s_shown;
    gpib_addr == $past(addr_wdata, 2);
  endsequence
  a_one_iface: assert property (gpib_active != serial_active)
    else $error("interface select not exclusive");
  a_legacy_bus: assert property (!scpi_mode [*4] |-> gpib_active)
    else $error("serial port active in legacy mode");
  a_addr_take: assert property (addr_wr && addr_wdata <= 5'h1e |=> s_store ##1 s_shown)
    else $error("bus address write lost");
  a_addr_refuse: assert property (
    addr_wr && addr_wdata > 5'h1e && !$past(addr_wr) |=> !nv_addr_wr)
    else $error("out of range address stored");
  a_st_result: assert property (st_done |=>
    st_pass == ($past(st_code) == 8'h00) && st_fail == !st_pass
    && (st_pass || st_reason == $past(st_code)))
    else $error("self-test result wrong");
  a_srq_boot: assert property ($rose(boot_done) |-> srq_pwrup == nv_srq_en)
    else $error("power-up service request wrong");
  a_srq_hold: assert property (srq_pwrup && !srq_ack |=> srq_pwrup)
    else $error("service request dropped without ack");
  a_boot_pick: assert property ($rose(boot_done) |->
    boot_to_default_state == (nv_boot_default || !nv_slot_valid)
    && recall_req == !boot_to_default_state && (!recall_req || recall_slot == nv_slot)
    && stored_setup_invalid_msg == (!nv_boot_default && !nv_slot_valid))
    else $error("power-up state choice wrong");
endmodule

// ### verif/rfc_top_tb.sv
// self-checking bench for the remote interface block
`timescale 1ns/1ps
`include "rfc_regs.svh"
module rfc_top_tb;
  import rfc_pkg::*;
  localparam int CLK = 1843200;
  localparam int AF = 12;
  logic sys_clk = 0, sys_rst = 1, cfg_wr = 0, cfg_serial_sel = 1, scpi_mode = 1;
  logic mode_change = 0, addr_wr = 0, nv_srq_en = 1, nv_boot_default = 0, nv_slot_valid = 1;
  logic srq_ack = 0, msg_ack = 0, st_done = 0, dsr = 1, cts = 1, tx_valid = 0, rx_ready = 0;
  logic [4:0] addr_wdata = 0, nv_addr = 5'h07;
  logic [3:0] nv_slot = 4'h8;
  logic [7:0] st_code = 0, tx_data = 0;
  rfc_baud_t cfg_baud = RFC_B9600;
  rfc_frame_t cfg_frame = RFC_NONE_8;
  rfc_flow_t cfg_flow = RFC_FLOW_NONE;
  logic rxd, nv_addr_wr, gpib_active, serial_active, srq_pwrup, boot_done, boot_to_default_state;
  logic recall_req, stored_setup_invalid_msg, st_pass, st_fail, txd, dtr, rts, tx_ready, rx_valid;
  logic rx_parity_err, rx_overrun;
  logic [4:0] nv_addr_wdata, gpib_addr;
  logic [3:0] recall_slot;
  logic [7:0] st_reason, rx_data;
  rfc_flow_t m[2] = '{RFC_FLOW_DTR, RFC_FLOW_RTS};
  int mismatches = 0, compares = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  rfc_top #(.CLK_HZ(CLK), .RX_DEPTH(16), .RX_ALMOST_FULL(AF)) uut (.*);
  rfc_host #(.BIT_CYC(32)) host (.sys_clk(sys_clk), .rxd(rxd));
  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rst;
    sys_rst = 1;
    ticks(3);
    sys_rst = 0;
    ticks(6);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    ticks(1);
    s = 0;
    ticks(3);
  endtask
  task automatic cfg(input rfc_baud_t b, input rfc_frame_t f, input rfc_flow_t fl);
    cfg_baud = b;
    cfg_frame = f;
    cfg_flow = fl;
    pulse(cfg_wr);
  endtask
  task automatic put(input logic [7:0] ch);
    int n = 0;
    tx_valid = 1;
    tx_data = ch;
    while (tx_ready !== 1'b1 && n < 5000) begin
      ticks(1);
      n++;
    end
    ticks(1);
    tx_valid = 0;
  endtask
  // frame sampled mid-bit; flow line may drop after start
  task automatic get(input int bt, input logic [9:0] exp, input rfc_flow_t drop);
    logic [9:0] f = '1;
    int n = 0;
    while (txd !== 1'b0 && n < 12 * bt) begin
      ticks(1);
      n++;
    end
    if (drop == RFC_FLOW_RTS) cts = 0;
    if (drop == RFC_FLOW_DTR) dsr = 0;
    ticks(bt / 2);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      ticks(bt);
    end
    chk(f, exp);
  endtask
  task automatic quiet(input int n);
    int lows = 0;
    repeat (n) begin
      ticks(1);
      if (txd !== 1'b1) lows++;
    end
    chk(lows, 0);
  endtask
  // ==========
  // scenarios
  task automatic t_ctl;
    rst();
    chk({gpib_active, serial_active, gpib_addr}, {2'h2, 5'h07});
    chk({boot_done, srq_pwrup, stored_setup_invalid_msg, txd, dtr, rts}, 6'h37);
    pulse(srq_ack);
    chk(srq_pwrup, 0);
    addr_wdata = 5'h1e;
    pulse(addr_wr);
    chk(gpib_addr, 5'h1e);
    addr_wdata = 5'h1f;
    pulse(addr_wr);
    chk(gpib_addr, 5'h1e);
    for (int i = 0; i < 2; i++) begin
      st_code = i ? 8'h5a : 8'h00;
      pulse(st_done);
      chk({st_pass, st_fail, st_reason}, i ? 10'h15a : 10'h200);
    end
    scpi_mode = 0;
    cfg(RFC_B57600, RFC_NONE_8, RFC_FLOW_NONE);
    chk(serial_active, 0);
    scpi_mode = 1;
    $display("test control done");
  endtask
  task automatic t_tx;
    int rate[6] = '{2400, 4800, 9600, 19200, 38400, 57600};
    for (int i = 0; i < 6; i++) begin
      cfg(rfc_baud_t'(i), RFC_NONE_8, RFC_FLOW_NONE);
      chk({gpib_active, serial_active}, 2'h1);
      put(8'h4b + i[7:0]);
      get(16 * (CLK / (rate[i] * 16)), {1'b1, 8'h4b + i[7:0], 1'b0}, RFC_FLOW_NONE);
    end
    cfg(RFC_B57600, RFC_EVEN_7, RFC_FLOW_NONE);
    put(8'h07);
    get(32, {2'h3, 7'h07, 1'b0}, RFC_FLOW_NONE);
    cfg(RFC_B57600, RFC_ODD_7, RFC_FLOW_NONE);
    put(8'h07);
    get(32, {2'h2, 7'h07, 1'b0}, RFC_FLOW_NONE);
    $display("test transmit done");
  endtask
  task automatic t_line;
    foreach (m[i]) begin
      {dsr, cts} = (m[i] == RFC_FLOW_DTR) ? 2'h1 : 2'h2;
      cfg(RFC_B57600, RFC_NONE_8, m[i]);
      put(8'h3c);
      quiet(160);
      {dsr, cts} = 2'h3;
      get(32, {1'b1, 8'h3c, 1'b0}, RFC_FLOW_NONE);
      put(8'hc3);
      get(32, {1'b1, 8'hc3, 1'b0}, m[i]);
      put(8'h5a);
      quiet(160);
      {dsr, cts} = 2'h3;
      get(32, {1'b1, 8'h5a, 1'b0}, RFC_FLOW_NONE);
    end
    $display("test line handshake done");
  endtask
  task automatic t_xon;
    cfg(RFC_B57600, RFC_NONE_8, RFC_FLOW_XON);
    host.send(`RFC_XOFF_CHAR);
    ticks(8);
    put(8'h66);
    quiet(160);
    chk(rx_valid, 0);
    host.send(`RFC_XON_CHAR);
    get(32, {1'b1, 8'h66, 1'b0}, RFC_FLOW_NONE);
    $display("test xon done");
  endtask
  task automatic t_buf;
    foreach (m[i]) begin
      cfg(RFC_B57600, RFC_NONE_8, m[i]);
      for (int k = 0; k <= AF; k++) begin
        chk({dtr, rts}, 2'h3);
        host.send(8'h40 + k[7:0]);
        ticks(4);
      end
      chk({dtr, rts}, (m[i] == RFC_FLOW_DTR) ? 2'h1 : 2'h2);
      chk({rx_overrun, rx_parity_err, rx_valid, rx_data}, 11'h140);
      pulse(rx_ready);
      chk({dtr, rts}, 2'h3);
      rx_ready = 1;
      ticks(20);
      rx_ready = 0;
      chk(rx_valid, 0);
    end
    pulse(mode_change);
    chk({gpib_active, serial_active, gpib_addr}, {2'h2, 5'h1e});
    $display("test buffer done");
  endtask
  task automatic t_boot;
    nv_srq_en = 0;
    nv_slot_valid = 0;
    rst();
    chk({srq_pwrup, stored_setup_invalid_msg, gpib_addr}, {2'h1, 5'h1e});
    pulse(msg_ack);
    chk(stored_setup_invalid_msg, 0);
    nv_boot_default = 1;
    rst();
    chk({boot_done, stored_setup_invalid_msg}, 2'h2);
    $display("test boot done");
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // main sequence and hang guard
  initial begin
    t_ctl();
    t_tx();
    t_line();
    t_xon();
    t_buf();
    t_boot();
    summarize();
  end
  always @(negedge sys_clk) begin
    if (nv_addr_wr) nv_addr = nv_addr_wdata;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end
endmodule
bind rfc_top rfc_top_asserts chk_i (.*);

// ### verilog/rfc_baud_gen.sv
// oversampling tick divider for the serial port
`timescale 1ns/1ps
`include "rfc_regs.svh"
module rfc_baud_gen #(
  parameter int CLK_HZ = `RFC_CLK_HZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // rate select and tick
  rfc_baud_if.gen bif
);
  import rfc_pkg::*;

  localparam int OVS = `RFC_OVERSAMPLE;

  // the fastest rate must still leave a divisor of at least two
  if (CLK_HZ / (`RFC_RATE_57600 * OVS) < 2) begin : g_chk
    $error("rfc_baud_gen: clock too slow for the highest bit rate");
  end

  // ==========================================================
  // divisor lookup
  logic [15:0] div_sel;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_reg;

  always_comb begin
    case (bif.baud_sel)
      RFC_B2400: div_sel = 16'(CLK_HZ / (`RFC_RATE_2400 * OVS) - 1);
      RFC_B4800: div_sel = 16'(CLK_HZ / (`RFC_RATE_4800 * OVS) - 1);
      RFC_B19200: div_sel = 16'(CLK_HZ / (`RFC_RATE_19200 * OVS) - 1);
      RFC_B38400: div_sel = 16'(CLK_HZ / (`RFC_RATE_38400 * OVS) - 1);
      RFC_B57600: div_sel = 16'(CLK_HZ / (`RFC_RATE_57600 * OVS) - 1);
      default: div_sel = 16'(CLK_HZ / (`RFC_RATE_9600 * OVS) - 1);
    endcase
  end

  // rate changes apply to the count in progress at once, so only the current tick period is off
  assign cnt_next = (cnt_reg >= div_sel) ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= (cnt_reg >= div_sel);
    end
  end

  assign bif.tick = tick_reg;
endmodule

// ### verilog/rfc_top.sv
// remote interface selection, serial port with flow control, power-up and self-test status
`timescale 1ns/1ps
`include "rfc_regs.svh"
// Behaviour
// (RQ1) bit rate 2400 to 57600 baud selectable, 9600 after reset
// (RQ2) framing none/8, even/7 or odd/7, none/8 after reset
// (RQ3) flow control none, xon/xoff, dtr/dsr or rts/cts, none after reset
// (RQ4) xon/xoff: stop sending after receiving character 13 hex
// (RQ5) xon/xoff: resume pending data after receiving character 11 hex
// (RQ6) dtr/dsr: send only while dsr is true
// (RQ7) dtr/dsr: dtr false when receive buffer nears 100 characters, released later
// (RQ8) rts/cts: send only while cts is true
// (RQ9) rts/cts: rts false when receive buffer nears 100 characters, released later
// (RQ10) host should use slow rates and short bursts without flow control
// (RQ11) exactly one interface active, instrument bus after reset
// (RQ12) bus address accepts 0 through 30, factory value 9
// (RQ13) bus address lives in non-volatile store, unchanged by reset
// (RQ14) system mode change forces instrument bus with stored address
// (RQ15) serial port configured and used only in standard command mode
// (RQ16) service request at power-up only when that option is enabled
// (RQ17) power-up restores reset state or chosen saved setup
// (RQ18) invalid saved setup falls back to reset state and flags failure
// (RQ19) self-test reports pass or the failure reason
// (RQ20) flow stop honoured only between characters, never mid-frame
module rfc_top #(
  parameter int CLK_HZ = `RFC_CLK_HZ,
  parameter int RX_DEPTH = `RFC_RX_DEPTH,
  parameter int RX_ALMOST_FULL = `RFC_RX_ALMOST_FULL
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration from the control side
  input wire logic cfg_wr,
  input wire rfc_pkg::rfc_baud_t cfg_baud,
  input wire rfc_pkg::rfc_frame_t cfg_frame,
  input wire rfc_pkg::rfc_flow_t cfg_flow,
  input wire logic cfg_serial_sel,
  input wire logic scpi_mode,
  input wire logic mode_change,
  // bus address and non-volatile store
  input wire logic addr_wr,
  input wire logic [4:0] addr_wdata,
  input wire logic [4:0] nv_addr,
  input wire logic nv_srq_en,
  input wire logic nv_boot_default,
  input wire logic [3:0] nv_slot,
  input wire logic nv_slot_valid,
  output logic nv_addr_wr,
  output logic [4:0] nv_addr_wdata,
  // interface status
  output logic gpib_active,
  output logic serial_active,
  output logic [4:0] gpib_addr,
  output logic srq_pwrup,
  input wire logic srq_ack,
  // power-up recall
  output logic boot_done,
  output logic boot_to_default_state,
  output logic recall_req,
  output logic [3:0] recall_slot,
  output logic stored_setup_invalid_msg,
  input wire logic msg_ack,
  // self-test
  input wire logic st_done,
  input wire logic [7:0] st_code,
  output logic st_pass,
  output logic st_fail,
  output logic [7:0] st_reason,
  // serial pins
  output logic txd,
  input wire logic rxd,
  input wire logic dsr,
  input wire logic cts,
  output logic dtr,
  output logic rts,
  // character stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_parity_err,
  output logic rx_overrun
);
  import rfc_pkg::*;

  localparam int AW = $clog2(RX_DEPTH);

  if (RX_ALMOST_FULL >= RX_DEPTH || RX_ALMOST_FULL < 1 || (1 << AW) != RX_DEPTH) begin : g_chk
    $error("rfc_top: receive buffer must be a power of two above almost-full");
  end

  // ==========================================================
  // configuration
  rfc_baud_t baud_reg;
  rfc_frame_t frame_reg;
  rfc_flow_t flow_reg;
  logic serial_reg;
  logic [4:0] addr_reg;
  logic cfg_take;
  logic addr_take;

  // serial settings can only change in standard command mode
  assign cfg_take = cfg_wr & scpi_mode; // RQ15
  assign addr_take = addr_wr & (addr_wdata <= `RFC_GPIB_ADDR_MAX); // RQ12

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_reg <= RFC_B9600; // RQ1
      frame_reg <= RFC_NONE_8; // RQ2
      flow_reg <= RFC_FLOW_NONE; // RQ3
    end else if (cfg_take) begin
      baud_reg <= cfg_baud; // RQ1
      frame_reg <= cfg_frame; // RQ2
      flow_reg <= cfg_flow; // RQ3
    end
  end

  // a single select bit cannot leave both or neither interface active
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_reg <= 1'b0; // RQ11
    end else if (mode_change || !scpi_mode) begin
      serial_reg <= 1'b0; // RQ14 RQ15
    end else if (cfg_take) begin
      serial_reg <= cfg_serial_sel; // RQ11
    end
  end

  // ==========================================================
  // power-up sequence
  rfc_boot_st_t boot_reg;
  rfc_boot_st_t boot_next;
  logic boot_load;
  logic boot_apply;

  assign boot_load = (boot_reg == RFC_BOOT_LOAD);
  assign boot_apply = (boot_reg == RFC_BOOT_APPLY);

  always_comb begin
    case (boot_reg)
      RFC_BOOT_LOAD: boot_next = RFC_BOOT_APPLY;
      RFC_BOOT_APPLY: boot_next = RFC_BOOT_DONE;
      RFC_BOOT_DONE: boot_next = RFC_BOOT_DONE;
      default: boot_next = RFC_BOOT_LOAD;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_reg <= RFC_BOOT_LOAD;
      boot_done <= 1'b0;
      boot_to_default_state <= 1'b0;
      recall_req <= 1'b0;
      recall_slot <= 4'h0;
    end else begin
      boot_reg <= boot_next;
      boot_done <= boot_apply | boot_done;
      boot_to_default_state <= boot_apply & (nv_boot_default | !nv_slot_valid); // RQ17 RQ18
      recall_req <= boot_apply & !nv_boot_default & nv_slot_valid; // RQ17
      recall_slot <= boot_apply ? nv_slot : recall_slot;
    end
  end

  // failure message stays until acknowledged; a new failure wins over the ack
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stored_setup_invalid_msg <= 1'b0;
    end else if (boot_apply && !nv_boot_default && !nv_slot_valid) begin
      stored_setup_invalid_msg <= 1'b1; // RQ18
    end else if (msg_ack) begin
      stored_setup_invalid_msg <= 1'b0;
    end
  end

  // address resets to the factory value, then is copied from the store during the load step if in range
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= `RFC_GPIB_ADDR_FACTORY;
      nv_addr_wr <= 1'b0;
      nv_addr_wdata <= `RFC_GPIB_ADDR_FACTORY;
      srq_pwrup <= 1'b0;
    end else begin
      nv_addr_wr <= addr_take; // RQ13
      nv_addr_wdata <= addr_take ? addr_wdata : nv_addr_wdata;
      if (boot_load) begin
        addr_reg <= (nv_addr <= `RFC_GPIB_ADDR_MAX) ? nv_addr : `RFC_GPIB_ADDR_FACTORY; // RQ13
      end else if (addr_take) begin
        addr_reg <= addr_wdata; // RQ12
      end
      if (boot_apply && nv_srq_en) begin
        srq_pwrup <= 1'b1; // RQ16
      end else if (srq_ack) begin
        srq_pwrup <= 1'b0;
      end
    end
  end

  // ==========================================================
  // self-test result
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_pass <= 1'b0;
      st_fail <= 1'b0;
      st_reason <= `RFC_SELFTEST_PASS;
    end else if (st_done) begin
      st_pass <= (st_code == `RFC_SELFTEST_PASS); // RQ19
      st_fail <= (st_code != `RFC_SELFTEST_PASS); // RQ19
      st_reason <= st_code; // RQ19
    end
  end

  // ==========================================================
  // bit-rate divider
  rfc_baud_if bif ();
  assign bif.baud_sel = baud_reg; // RQ1

  rfc_baud_gen #(.CLK_HZ(CLK_HZ)) u_baud (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bif(bif)
  );

  // ==========================================================
  // transmitter
  rfc_ser_st_t tx_st_reg;
  logic [3:0] tx_tick_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] hold_reg;
  logic hold_valid_reg;
  logic paused_reg;
  logic flow_ok;
  logic tx_start;
  logic tx_accept;
  logic tx_bit_end;
  logic [7:0] tx_word;

  // with seven data bits the parity takes the eighth slot
  assign tx_word = (frame_reg == RFC_EVEN_7) ? {^hold_reg[6:0], hold_reg[6:0]} :
                   (frame_reg == RFC_ODD_7) ? {~^hold_reg[6:0], hold_reg[6:0]} :
                   hold_reg; // RQ2
  assign flow_ok = (flow_reg == RFC_FLOW_XON) ? !paused_reg : // RQ4 RQ5
                   (flow_reg == RFC_FLOW_DTR) ? dsr : // RQ6
                   (flow_reg == RFC_FLOW_RTS) ? cts : // RQ8
                   1'b1;
  // flow is looked at only when idle, so a frame in flight always completes
  assign tx_start = (tx_st_reg == RFC_S_IDLE) & hold_valid_reg & flow_ok & serial_reg; // RQ20
  assign tx_accept = tx_valid & tx_ready;
  assign tx_bit_end = bif.tick & (tx_tick_reg == `RFC_LAST_TICK);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_valid_reg <= 1'b0;
      hold_reg <= 8'h00;
      tx_ready <= 1'b0;
    end else begin
      hold_valid_reg <= tx_accept | (hold_valid_reg & !tx_start);
      hold_reg <= tx_accept ? tx_data : hold_reg;
      tx_ready <= !(tx_accept | (hold_valid_reg & !tx_start));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_reg <= RFC_S_IDLE;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      txd <= 1'b1;
    end else begin
      tx_tick_reg <= (tx_st_reg == RFC_S_IDLE) ? 4'h0 : tx_tick_reg + {3'h0, bif.tick};
      case (tx_st_reg)
        RFC_S_IDLE: begin
          txd <= !tx_start;
          if (tx_start) begin
            tx_sh_reg <= tx_word;
            tx_st_reg <= RFC_S_START;
          end
        end
        RFC_S_START: begin
          if (tx_bit_end) begin
            txd <= tx_sh_reg[0];
            tx_bit_reg <= 3'h0;
            tx_st_reg <= RFC_S_DATA;
          end
        end
        RFC_S_DATA: begin
          if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            txd <= (tx_bit_reg == 3'h7) ? 1'b1 : tx_sh_reg[1];
            tx_st_reg <= (tx_bit_reg == 3'h7) ? RFC_S_STOP : RFC_S_DATA;
          end
        end
        RFC_S_STOP: begin
          if (tx_bit_end) begin
            tx_st_reg <= RFC_S_IDLE;
          end
        end
        default: begin
          tx_st_reg <= RFC_S_IDLE;
          txd <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // receiver
  rfc_ser_st_t rx_st_reg;
  logic [3:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_done;
  logic rx_mid;
  logic rx_par_bad;
  logic rx_is_xoff;
  logic rx_is_xon;
  logic [7:0] rx_char;

  assign rx_mid = bif.tick & (rx_tick_reg == `RFC_HALF_BIT);
  assign rx_done = (rx_st_reg == RFC_S_STOP) & rx_mid & rxd;
  assign rx_char = (frame_reg == RFC_NONE_8) ? rx_sh_reg : {1'b0, rx_sh_reg[6:0]};
  assign rx_par_bad = (frame_reg == RFC_EVEN_7) ? ^rx_sh_reg :
                      (frame_reg == RFC_ODD_7) ? ~^rx_sh_reg : 1'b0; // RQ2
  assign rx_is_xoff = (flow_reg == RFC_FLOW_XON) & (rx_char == `RFC_XOFF_CHAR);
  assign rx_is_xon = (flow_reg == RFC_FLOW_XON) & (rx_char == `RFC_XON_CHAR);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_reg <= RFC_S_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
    end else begin
      rx_tick_reg <= (rx_st_reg == RFC_S_IDLE) ? 4'h0 : rx_tick_reg + {3'h0, bif.tick};
      case (rx_st_reg)
        RFC_S_IDLE: begin
          if (!rxd && serial_reg) begin
            rx_st_reg <= RFC_S_START;
          end
        end
        RFC_S_START: begin
          if (rx_mid) begin
            rx_st_reg <= rxd ? RFC_S_IDLE : RFC_S_DATA;
            rx_bit_reg <= 3'h0;
          end
        end
        RFC_S_DATA: begin
          if (rx_mid) begin
            rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            rx_st_reg <= (rx_bit_reg == 3'h7) ? RFC_S_STOP : RFC_S_DATA;
          end
        end
        RFC_S_STOP: begin
          // a low stop bit is a framing fault and the character is dropped
          if (rx_mid) begin
            rx_st_reg <= RFC_S_IDLE;
          end
        end
        default: rx_st_reg <= RFC_S_IDLE;
      endcase
    end
  end

  // in xon/xoff mode handshake characters are consumed here and never reach the buffer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      paused_reg <= 1'b0;
    end else if (flow_reg != RFC_FLOW_XON) begin
      paused_reg <= 1'b0;
    end else if (rx_done && rx_is_xoff) begin
      paused_reg <= 1'b1; // RQ4
    end else if (rx_done && rx_is_xon) begin
      paused_reg <= 1'b0; // RQ5
    end
  end

  // ==========================================================
  // receive buffer
  logic [8:0] rx_mem [RX_DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic buf_push;
  logic buf_pop;
  logic buf_full;
  logic buf_empty;
  logic near_full;

  assign buf_full = (count_reg == (AW+1)'(RX_DEPTH));
  assign buf_empty = (count_reg == '0);
  assign buf_push = rx_done & !rx_is_xoff & !rx_is_xon & !buf_full;
  assign buf_pop = !buf_empty & (!rx_valid | rx_ready);
  assign near_full = (count_reg >= (AW+1)'(RX_ALMOST_FULL));

  always_ff @(posedge sys_clk) begin
    if (buf_push) begin
      rx_mem[wr_ptr_reg] <= {rx_par_bad, rx_char};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(buf_push);
      rd_ptr_reg <= rd_ptr_reg + AW'(buf_pop);
      count_reg <= count_reg + (AW+1)'(buf_push) - (AW+1)'(buf_pop);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_parity_err <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_valid <= buf_pop | (rx_valid & !rx_ready);
      if (buf_pop) begin
        rx_data <= rx_mem[rd_ptr_reg][7:0];
        rx_parity_err <= rx_mem[rd_ptr_reg][8];
      end
      rx_overrun <= rx_overrun | (rx_done & buf_full);
    end
  end

  // ==========================================================
  // line handshake outputs and status
  // dtr (dtr/dsr mode only) and rts (rts/cts mode only) fall at the almost-full level and rise as soon as it is left
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dtr <= 1'b1;
      rts <= 1'b1;
      gpib_active <= 1'b1;
      serial_active <= 1'b0;
      gpib_addr <= `RFC_GPIB_ADDR_FACTORY;
    end else begin
      dtr <= !((flow_reg == RFC_FLOW_DTR) & near_full); // RQ7
      rts <= !((flow_reg == RFC_FLOW_RTS) & near_full); // RQ9
      gpib_active <= !serial_reg; // RQ11
      serial_active <= serial_reg; // RQ11
      gpib_addr <= addr_reg;
    end
  end
endmodule
